// File: rtl/lpddr_bank_tracker.sv
// Bank state tracker of a four-bank low-power DDR2 memory device.
// Assumes the controller drives ck_i, cke_i and a decoded command bus;
// all of them are asynchronous to clk_i and are synchronised here.
//
// Function
// - Commands count only when CKE is high on two successive link edges.
// - A bank is idle after precharge plus tRP; only then accepts idle commands.
// - Activate to idle bank opens the row; active after tRCD.
// - Precharge closes the row; bank idle once tRP has passed.
// - Read with auto precharge keeps bank busy until tRP after internal precharge.
// - Write with auto precharge keeps bank busy until tRP after internal precharge.
// - Per-bank refresh needs that bank idle; idle again after tRFCpb.
// - All-bank refresh needs all banks idle; all idle after tRFCab.
// - Register write needs all banks idle; all idle after tMRW.
// - Register read while idle lasts tMRR, then all banks idle.
// - Register read to an active bank lasts tMRR, then bank active again.
// - Register read while resetting lasts tMRR, then all banks idle.
// - Reset from power-on or all idle starts initialisation; not bank-specific.
// - Precharge to an idle bank is allowed and still takes tRP.
// - Precharge-all needs every bank prechargeable; all idle after tRP.
// - Burst stop ignores bank and ends the latest burst if it has no auto precharge; bank returns active.
// - New read or write honours its own auto precharge setting.
// - NOP keeps all states; outside device-wide periods other banks take commands their state allows.
`timescale 1ns/1ps
module lpddr_bank_tracker #(
    parameter int BL = lpddr_bank_pkg::BL_DEF  // Burst length: 4, 8 or 16
) (
    input  wire logic                       clk_i,        // Core clock
    input  wire logic                       rst_b_i,      // Async reset, low
    input  wire logic                       ck_i,         // Link clock pin
    input  wire logic                       cke_i,        // Clock enable pin
    input  lpddr_bank_pkg::cmd_s            cmd_i,        // Command bus pins
    output lpddr_bank_pkg::dev_e            dev_state_o,  // Device state
    output lpddr_bank_pkg::bank_e           bank0_o,      // Bank 0 state
    output lpddr_bank_pkg::bank_e           bank1_o,      // Bank 1 state
    output lpddr_bank_pkg::bank_e           bank2_o,      // Bank 2 state
    output lpddr_bank_pkg::bank_e           bank3_o,      // Bank 3 state
    output logic [lpddr_bank_pkg::ROW_W-1:0] row0_o,      // Bank 0 open row
    output logic [lpddr_bank_pkg::ROW_W-1:0] row1_o,      // Bank 1 open row
    output logic [lpddr_bank_pkg::ROW_W-1:0] row2_o,      // Bank 2 open row
    output logic [lpddr_bank_pkg::ROW_W-1:0] row3_o,      // Bank 3 open row
    output logic                            all_idle_o,   // All banks idle
    output logic                            cmd_ok_o,     // Command taken
    output logic                            cmd_err_o     // Command refused
);
    import lpddr_bank_pkg::*;

    // =========================================================
    // Parameter check
    if (!(BL == 4 || BL == 8 || BL == 16)) begin : g_bad_bl
        $error("BL must be 4, 8 or 16");
    end

    // =========================================================
    // Device state, shared timer and burst owner
    typedef struct packed {
        dev_e             st;
        logic [CNT_W-1:0] cnt;
        logic [BA_W-1:0]  last_ba;
        logic             all_idle;
        logic             ok;
        logic             err;
    } dev_s;

    dev_s                   s_q;
    dev_s                   s_d;
    logic                   ln_edge;
    logic                   ln_ok;
    cmd_s                   ln_cmd;
    bank_e                  bst [NUM_BANKS];
    logic [ROW_W-1:0]       rows [NUM_BANKS];
    logic [NUM_BANKS-1:0]   go;
    logic [NUM_BANKS-1:0]   bst_hit;
    logic [NUM_BANKS-1:0]   idle_v;
    logic [NUM_BANKS-1:0]   pre_v;
    logic                   all_idle;
    logic                   all_pre;
    logic                   legal;
    bank_e                  tgt;

    // Bank may take a precharge in this state
    function automatic logic pre_ok(input bank_e s);
        return (s == BK_IDLE) || (s == BK_ACTIVE) ||
               (s == BK_READING) || (s == BK_WRITING);
    endfunction : pre_ok

    // Bank has a read or write burst running
    function automatic logic in_burst(input bank_e s);
        return (s == BK_READING) || (s == BK_WRITING) ||
               (s == BK_RD_AP) || (s == BK_WR_AP);
    endfunction : in_burst

    // =========================================================
    // Link capture
    link_sampler u_link (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .ck_i     (ck_i),
        .cke_i    (cke_i),
        .cmd_i    (cmd_i),
        .edge_o   (ln_edge),
        .cke_ok_o (ln_ok),
        .cmd_o    (ln_cmd)
    );

    // =========================================================
    // Four bank machines
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        bank_fsm #(
            .BURST_EDGES (BL / 2)
        ) u_bank (
            .clk_i   (clk_i),
            .rst_b_i (rst_b_i),
            .go_i    (go[b]),
            .cmd_i   (ln_cmd),
            .edge_i  (ln_edge),
            .bst_i   (bst_hit[b]),
            .state_o (bst[b]),
            .row_o   (rows[b])
        );
    end

    // Summary of bank states
    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            idle_v[b] = (bst[b] == BK_IDLE);
            pre_v[b]  = pre_ok(bst[b]);
        end
        all_idle = &idle_v;
        all_pre  = &pre_v;
        tgt      = bst[ln_cmd.ba];
    end

    // =========================================================
    // Command check and device state machine
    always_comb begin
        s_d          = s_q;
        s_d.ok       = 1'b0;
        s_d.err      = 1'b0;
        s_d.all_idle = all_idle && (s_d.st != DV_POWER_ON);
        go           = '0;
        bst_hit      = '0;
        legal        = 1'b0;
        if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - C_ONE;
        end
        // Device-wide periods end on the shared timer
        if (s_q.cnt == C_ONE) begin
            case (s_q.st)
                DV_RESETTING,
                DV_REF_PB,
                DV_REF_AB,
                DV_MRW,
                DV_MRR_IDLE,
                DV_MRR_ACT,
                DV_MRR_RESET,
                DV_PRE_ALL:    s_d.st = DV_NORMAL;
                default:       s_d.st = s_q.st;
            endcase
        end
        // A NOP or an unqualified edge changes nothing
        if (ln_edge && ln_ok && ln_cmd.cmd != CMD_NOP) begin
            case (s_q.st)
                DV_POWER_ON: begin
                    if (ln_cmd.cmd == CMD_RESET) begin
                        legal   = 1'b1;
                        s_d.st  = DV_RESETTING;
                        s_d.cnt = C_INIT5;
                    end
                end
                DV_RESETTING: begin
                    if (ln_cmd.cmd == CMD_MRR) begin
                        legal   = 1'b1;
                        s_d.st  = DV_MRR_RESET;
                        s_d.cnt = C_MRR;
                    end
                end
                DV_NORMAL: begin
                    case (ln_cmd.cmd)
                        CMD_ACT: begin
                            legal = (tgt == BK_IDLE);
                            go[ln_cmd.ba] = legal;
                        end
                        CMD_RD,
                        CMD_WR: begin
                            legal = (tgt == BK_ACTIVE) ||
                                    (tgt == BK_READING) ||
                                    (tgt == BK_WRITING);
                            go[ln_cmd.ba] = legal;
                            if (legal) begin
                                s_d.last_ba = ln_cmd.ba;
                            end
                        end
                        CMD_BST: begin
                            legal = (bst[s_q.last_ba] == BK_READING) ||
                                    (bst[s_q.last_ba] == BK_WRITING);
                            bst_hit[s_q.last_ba] = legal;
                        end
                        CMD_PRE: begin
                            if (ln_cmd.ap) begin
                                legal = all_pre;
                                go    = {NUM_BANKS{legal}};
                                if (legal) begin
                                    s_d.st  = DV_PRE_ALL;
                                    s_d.cnt = C_RP;
                                end
                            end else begin
                                legal = pre_ok(tgt);
                                go[ln_cmd.ba] = legal;
                            end
                        end
                        CMD_REF_PB: begin
                            legal = (tgt == BK_IDLE) && !in_burst(tgt);
                            go[ln_cmd.ba] = legal;
                            if (legal) begin
                                s_d.st  = DV_REF_PB;
                                s_d.cnt = C_RFCPB;
                            end
                        end
                        CMD_REF_AB: begin
                            legal = all_idle;
                            if (legal) begin
                                s_d.st  = DV_REF_AB;
                                s_d.cnt = C_RFCAB;
                            end
                        end
                        CMD_MRW: begin
                            legal = all_idle;
                            if (legal) begin
                                s_d.st  = DV_MRW;
                                s_d.cnt = C_MRW;
                            end
                        end
                        CMD_MRR: begin
                            if (all_idle) begin
                                legal   = 1'b1;
                                s_d.st  = DV_MRR_IDLE;
                                s_d.cnt = C_MRR;
                            end else if (tgt == BK_ACTIVE) begin
                                legal   = 1'b1;
                                go[ln_cmd.ba] = 1'b1;
                                s_d.st  = DV_MRR_ACT;
                                s_d.cnt = C_MRR;
                            end
                        end
                        CMD_RESET: begin
                            legal = all_idle;
                            if (legal) begin
                                s_d.st  = DV_RESETTING;
                                s_d.cnt = C_INIT5;
                            end
                        end
                        default: legal = 1'b0;
                    endcase
                end
                // Refresh, register access and precharge-all take no command
                default: legal = 1'b0;
            endcase
            s_d.ok  = legal;
            s_d.err = !legal;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // Outputs
    assign dev_state_o = s_q.st;
    assign all_idle_o  = s_q.all_idle;
    assign cmd_ok_o    = s_q.ok;
    assign cmd_err_o   = s_q.err;
    assign bank0_o     = bst[0];
    assign bank1_o     = bst[1];
    assign bank2_o     = bst[2];
    assign bank3_o     = bst[3];
    assign row0_o      = rows[0];
    assign row1_o      = rows[1];
    assign row2_o      = rows[2];
    assign row3_o      = rows[3];

endmodule : lpddr_bank_tracker

// File: rtl/lpddr_bank_pkg.sv
// Shared types, timing counts and command codes for the bank state tracker.
// Assumes a 100 MHz core clock; all times are rounded up to whole cycles.
package lpddr_bank_pkg;

    // =========================================================
    // Geometry
    localparam int NUM_BANKS = 4;
    localparam int BA_W      = 2;
    localparam int ROW_W     = 13;
    localparam int CNT_W     = 16;
    localparam int BL_DEF    = 8;    // Default burst length in data beats

    // =========================================================
    // Timing
    localparam int unsigned CLK_MHZ     = 100;
    localparam int unsigned T_RCD_NS    = 18;
    localparam int unsigned T_RP_NS     = 18;
    localparam int unsigned T_RFCPB_NS  = 60;
    localparam int unsigned T_RFCAB_NS  = 130;
    localparam int unsigned T_MRW_NS    = 50;
    localparam int unsigned T_MRR_NS    = 20;
    localparam int unsigned T_INIT5_NS  = 10000;

    // Least time in ns to clock cycles, rounded up, never below one
    function automatic int unsigned ns2cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : ns2cyc

    localparam logic [CNT_W-1:0] C_RCD   = CNT_W'(ns2cyc(T_RCD_NS));
    localparam logic [CNT_W-1:0] C_RP    = CNT_W'(ns2cyc(T_RP_NS));
    localparam logic [CNT_W-1:0] C_RFCPB = CNT_W'(ns2cyc(T_RFCPB_NS));
    localparam logic [CNT_W-1:0] C_RFCAB = CNT_W'(ns2cyc(T_RFCAB_NS));
    localparam logic [CNT_W-1:0] C_MRW   = CNT_W'(ns2cyc(T_MRW_NS));
    localparam logic [CNT_W-1:0] C_MRR   = CNT_W'(ns2cyc(T_MRR_NS));
    localparam logic [CNT_W-1:0] C_INIT5 = CNT_W'(ns2cyc(T_INIT5_NS));
    localparam logic [CNT_W-1:0] C_ONE   = CNT_W'(1);

    // =========================================================
    // Commands, states and carriers
    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE,
        CMD_REF_PB, CMD_REF_AB, CMD_MRW, CMD_MRR, CMD_RESET
    } cmd_e;

    typedef enum logic [3:0] {
        BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING,
        BK_RD_AP, BK_WR_AP, BK_AP_PRE, BK_PRECHARGING, BK_REFRESHING,
        BK_ACT_MRR
    } bank_e;

    typedef enum logic [3:0] {
        DV_POWER_ON, DV_RESETTING, DV_NORMAL, DV_REF_PB, DV_REF_AB,
        DV_MRW, DV_MRR_IDLE, DV_MRR_ACT, DV_MRR_RESET, DV_PRE_ALL
    } dev_e;

    typedef struct packed {
        cmd_e             cmd;   // Decoded command
        logic [BA_W-1:0]  ba;    // Bank address
        logic             ap;    // Auto precharge / all-bank flag
        logic [ROW_W-1:0] row;   // Row address for activate
    } cmd_s;

endpackage : lpddr_bank_pkg

// File: rtl/link_sampler.sv
// Samples the controller clock, clock enable and command bus into clk_i.
// Assumes the link clock is much slower than clk_i and the bus is stable
// around each link rising edge.
`timescale 1ns/1ps
module link_sampler (
    input  wire logic                 clk_i,    // Core clock
    input  wire logic                 rst_b_i,  // Async reset, active low
    input  wire logic                 ck_i,     // Link clock pin
    input  wire logic                 cke_i,    // Clock enable pin
    input  lpddr_bank_pkg::cmd_s      cmd_i,    // Command bus pins
    output logic                      edge_o,   // Link rising edge pulse
    output logic                      cke_ok_o, // CKE high on two edges
    output lpddr_bank_pkg::cmd_s      cmd_o     // Command at that edge
);
    import lpddr_bank_pkg::*;

    typedef struct packed {
        logic ck_meta;
        logic ck_sync;
        logic ck_last;
        logic cke_meta;
        logic cke_sync;
        logic cke_prev;
        cmd_s cmd_meta;
        cmd_s cmd_sync;
        logic edge_hit;
        logic ok;
        cmd_s cmd;
    } smp_s;

    smp_s s_q;
    smp_s s_d;

    // =========================================================
    // Two-flop capture, edge detect on the synced copy
    always_comb begin
        s_d          = s_q;
        s_d.ck_meta  = ck_i;
        s_d.ck_sync  = s_q.ck_meta;
        s_d.ck_last  = s_q.ck_sync;
        s_d.cke_meta = cke_i;
        s_d.cke_sync = s_q.cke_meta;
        s_d.cmd_meta = cmd_i;
        s_d.cmd_sync = s_q.cmd_meta;
        s_d.edge_hit = s_q.ck_sync & ~s_q.ck_last;
        if (s_q.ck_sync && !s_q.ck_last) begin
            s_d.ok       = s_q.cke_sync & s_q.cke_prev;
            s_d.cke_prev = s_q.cke_sync;
            s_d.cmd      = s_q.cmd_sync;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign edge_o   = s_q.edge_hit;
    assign cke_ok_o = s_q.ok;
    assign cmd_o    = s_q.cmd;

endmodule : link_sampler

// File: rtl/bank_fsm.sv
// State machine and timers of one bank.
// Assumes the tracker passes only commands already found legal for it.
`timescale 1ns/1ps
module bank_fsm #(
    parameter int BURST_EDGES = 4      // Link edges per burst
) (
    input  wire logic                              clk_i,   // Core clock
    input  wire logic                              rst_b_i, // Async reset, low
    input  wire logic                              go_i,    // Accepted command
    input  lpddr_bank_pkg::cmd_s                   cmd_i,   // That command
    input  wire logic                              edge_i,  // Link edge pulse
    input  wire logic                              bst_i,   // Burst stop hit
    output lpddr_bank_pkg::bank_e                  state_o, // Bank state
    output logic [lpddr_bank_pkg::ROW_W-1:0]       row_o    // Open row
);
    import lpddr_bank_pkg::*;

    localparam logic [CNT_W-1:0] C_BURST = CNT_W'(BURST_EDGES);

    typedef struct packed {
        bank_e            st;
        logic [CNT_W-1:0] cnt;
        logic [ROW_W-1:0] row;
    } bank_s;

    bank_s s_q;
    bank_s s_d;
    logic  burst;
    logic  done;

    // =========================================================
    // Next state: time-outs first, then the accepted command
    always_comb begin
        s_d   = s_q;
        burst = (s_q.st == BK_READING) || (s_q.st == BK_WRITING) ||
                (s_q.st == BK_RD_AP) || (s_q.st == BK_WR_AP);
        done  = (s_q.cnt == C_ONE) && (!burst || edge_i);
        if (s_q.cnt != '0 && (!burst || edge_i)) begin
            s_d.cnt = s_q.cnt - C_ONE;
        end
        if (done) begin
            case (s_q.st)
                BK_ACTIVATING: s_d.st = BK_ACTIVE;
                BK_READING,
                BK_WRITING:    s_d.st = BK_ACTIVE;
                BK_ACT_MRR:    s_d.st = BK_ACTIVE;
                BK_RD_AP,
                BK_WR_AP: begin
                    s_d.st  = BK_AP_PRE;
                    s_d.cnt = C_RP;
                end
                default:       s_d.st = BK_IDLE;
            endcase
        end
        if (bst_i) begin
            s_d.st  = BK_ACTIVE;
            s_d.cnt = '0;
        end
        if (go_i) begin
            case (cmd_i.cmd)
                CMD_ACT: begin
                    s_d.st  = BK_ACTIVATING;
                    s_d.cnt = C_RCD;
                    s_d.row = cmd_i.row;
                end
                CMD_RD: begin
                    s_d.st  = cmd_i.ap ? BK_RD_AP : BK_READING;
                    s_d.cnt = C_BURST;
                end
                CMD_WR: begin
                    s_d.st  = cmd_i.ap ? BK_WR_AP : BK_WRITING;
                    s_d.cnt = C_BURST;
                end
                CMD_PRE: begin
                    s_d.st  = BK_PRECHARGING;
                    s_d.cnt = C_RP;
                end
                CMD_REF_PB: begin
                    s_d.st  = BK_REFRESHING;
                    s_d.cnt = C_RFCPB;
                end
                CMD_MRR: begin
                    s_d.st  = BK_ACT_MRR;
                    s_d.cnt = C_MRR;
                end
                default: s_d.st = s_q.st;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign state_o = s_q.st;
    assign row_o   = s_q.row;

endmodule : bank_fsm

// File: testbench/lpddr_bank_tracker_chk.sv
// Port checker of the bank tracker, bound into every tracker instance.
// Assumes the package timing and the default burst length.
`timescale 1ns/1ps
module lpddr_bank_tracker_chk (
    input wire logic            clk_i,       // Core clock
    input wire logic            rst_b_i,     // Reset, low
    input lpddr_bank_pkg::dev_e dev_state_o, // Device state
    input lpddr_bank_pkg::bank_e bank0_o,    // Bank 0 state
    input lpddr_bank_pkg::bank_e bank1_o,    // Bank 1 state
    input wire logic            all_idle_o,  // All idle
    input wire logic            cmd_ok_o     // Command taken
);
    import lpddr_bank_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_act; $rose(bank1_o == BK_ACTIVATING) |-> ##[1:2] bank1_o == BK_ACTIVE; endproperty
    a_act: assert property (p_act) else $error("activate too long");
    property p_pre; $rose(bank0_o == BK_PRECHARGING) |-> ##[1:2] bank0_o == BK_IDLE; endproperty
    a_pre: assert property (p_pre) else $error("precharge too long");
    property p_refab; $rose(dev_state_o == DV_REF_AB) |->
        (dev_state_o == DV_REF_AB)[*8] ##[4:7] dev_state_o == DV_NORMAL; endproperty
    a_refab: assert property (p_refab) else $error("refresh span wrong");
    property p_mrw; $rose(dev_state_o == DV_MRW) |-> ##[4:5] dev_state_o == DV_NORMAL; endproperty
    a_mrw: assert property (p_mrw) else $error("register write span wrong");
    property p_mrr; $rose(dev_state_o == DV_MRR_IDLE) |-> ##[1:2] dev_state_o == DV_NORMAL;
    endproperty
    a_mrr: assert property (p_mrr) else $error("register read span wrong");
    property p_quiet; dev_state_o inside {DV_REF_AB, DV_MRW, DV_MRR_IDLE, DV_PRE_ALL}
        && $stable(dev_state_o) |-> !cmd_ok_o; endproperty
    a_quiet: assert property (p_quiet) else $error("command taken while busy");
    property p_idle; all_idle_o |-> $past(bank0_o) == BK_IDLE && $past(bank1_o) == BK_IDLE
        && $past(dev_state_o) != DV_POWER_ON; endproperty
    a_idle: assert property (p_idle) else $error("idle flag wrong");
    property p_rst; $rose(dev_state_o == DV_RESETTING) |->
        $past(dev_state_o) inside {DV_POWER_ON, DV_NORMAL}; endproperty
    a_rst: assert property (p_rst) else $error("reset from bad state");
endmodule : lpddr_bank_tracker_chk
bind lpddr_bank_tracker lpddr_bank_tracker_chk chk (.*);

// File: testbench/ctrl_model.sv
// Controller model: free-running 80 ns link clock, clock enable, commands.
// Assumes send is called at most once per link cycle.
`timescale 1ns/1ps
module ctrl_model (
    input  wire logic           clk_i,  // Core clock
    output logic                ck_o,   // Link clock
    output logic                cke_o,  // Clock enable
    output lpddr_bank_pkg::cmd_s cmd_o  // Command bus
);
    import lpddr_bank_pkg::*;
    logic [2:0] cnt_q = 3'h0;
    assign ck_o = cnt_q[2];
    // Enable held high so every link edge counts
    initial begin
        cke_o = 1'b1;
        cmd_o = '{CMD_NOP, 2'h0, 1'b0, 13'h0};
    end
    // Link clock; a command is withdrawn at its falling link edge, fields scrambled
    always @(negedge clk_i) begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) cmd_o <= '{CMD_NOP, ~cmd_o.ba, ~cmd_o.ap, ~cmd_o.row};
    end
    // Place one command two core cycles before a rising link edge
    task automatic send(input cmd_s c);
        do @(negedge clk_i); while (cnt_q != 3'h1);
        cmd_o = c;
    endtask : send
endmodule : ctrl_model

// File: testbench/lpddr_bank_tracker_test.sv
// Self-checking bench of the bank tracker driven by the controller model.
// Assumes burst length 8, so a burst spans four link edges.
`timescale 1ns/1ps
module lpddr_bank_tracker_test;
    import lpddr_bank_pkg::*;
    logic             clk_i = 1'b0;
    logic             rst_b_i = 1'b0;
    logic             ck_i, cke_i, idle, ok, err;
    cmd_s             cmd_i;
    dev_e             dev;
    bank_e            bk [4];
    logic [ROW_W-1:0] row [4];
    int               failures = 0;
    int               cmp_count = 0;
    always #5 clk_i = ~clk_i;
    ctrl_model m (.clk_i(clk_i), .ck_o(ck_i), .cke_o(cke_i), .cmd_o(cmd_i));
    lpddr_bank_tracker dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ck_i(ck_i), .cke_i(cke_i),
        .cmd_i(cmd_i), .dev_state_o(dev), .bank0_o(bk[0]), .bank1_o(bk[1]), .bank2_o(bk[2]),
        .bank3_o(bk[3]), .row0_o(row[0]), .row1_o(row[1]), .row2_o(row[2]), .row3_o(row[3]),
        .all_idle_o(idle), .cmd_ok_o(ok), .cmd_err_o(err));
    // Compare one value
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Issue one command, await its reply pulse and check taken or refused
    task automatic go(input cmd_e c, input logic [1:0] b, input logic a, input logic e);
        int n = 0;
        m.send(cmd_s'{c, b, a, 13'h123});
        do begin @(negedge clk_i); n++; end while (ok !== 1'b1 && err !== 1'b1 && n < 12);
        chk("reply", {14'h0, e, ~e}, {14'h0, ok, err});
    endtask : go
    task automatic t_init;
        go(CMD_RESET, 2'h0, 1'b0, 1'b1); chk("dev", DV_RESETTING, dev);
        go(CMD_MRR, 2'h0, 1'b0, 1'b1); chk("dev", DV_MRR_RESET, dev);
        repeat (8) @(negedge clk_i);
        chk("dev", DV_NORMAL, dev); chk("idle", 16'h1, idle);
    endtask : t_init
    task automatic t_burst;
        go(CMD_ACT, 2'h1, 1'b0, 1'b1); chk("bk1", BK_ACTIVATING, bk[1]);
        repeat (3) @(negedge clk_i);
        chk("bk1", BK_ACTIVE, bk[1]); chk("row1", 16'h123, row[1]);
        go(CMD_RD, 2'h1, 1'b0, 1'b1); chk("bk1", BK_READING, bk[1]);
        go(CMD_BST, 2'h2, 1'b0, 1'b1); chk("bk1", BK_ACTIVE, bk[1]);
        go(CMD_BST, 2'h1, 1'b0, 1'b0);
        go(CMD_MRR, 2'h1, 1'b0, 1'b1); chk("dev", DV_MRR_ACT, dev);
        repeat (4) @(negedge clk_i);
        chk("bk1", BK_ACTIVE, bk[1]);
        go(CMD_WR, 2'h1, 1'b0, 1'b1); chk("bk1", BK_WRITING, bk[1]);
        go(CMD_BST, 2'h0, 1'b0, 1'b1); chk("bk1", BK_ACTIVE, bk[1]);
    endtask : t_burst
    task automatic t_autopre;
        go(CMD_RD, 2'h1, 1'b1, 1'b1); chk("bk1", BK_RD_AP, bk[1]);
        repeat (48) @(negedge clk_i);
        chk("bk1", BK_IDLE, bk[1]);
        go(CMD_ACT, 2'h1, 1'b0, 1'b1);
        go(CMD_WR, 2'h1, 1'b1, 1'b1); chk("bk1", BK_WR_AP, bk[1]);
        repeat (48) @(negedge clk_i);
        chk("bk1", BK_IDLE, bk[1]);
    endtask : t_autopre
    task automatic t_refresh;
        go(CMD_ACT, 2'h0, 1'b0, 1'b1); go(CMD_REF_AB, 2'h0, 1'b0, 1'b0);
        chk("row0", 16'h123, row[0]);
        go(CMD_PRE, 2'h0, 1'b0, 1'b1); chk("bk0", BK_PRECHARGING, bk[0]);
        go(CMD_REF_AB, 2'h0, 1'b0, 1'b1); go(CMD_ACT, 2'h2, 1'b0, 1'b0);
        chk("row2", 16'h0, row[2]);
        repeat (16) @(negedge clk_i);
        chk("dev", DV_NORMAL, dev);
    endtask : t_refresh
    task automatic t_misc;
        go(CMD_PRE, 2'h2, 1'b0, 1'b1); chk("bk2", BK_PRECHARGING, bk[2]);
        go(CMD_MRW, 2'h0, 1'b0, 1'b1); chk("dev", DV_MRW, dev);
        go(CMD_REF_PB, 2'h3, 1'b0, 1'b1); chk("bk3", BK_REFRESHING, bk[3]);
        repeat (8) @(negedge clk_i);
        go(CMD_PRE, 2'h0, 1'b1, 1'b1); chk("dev", DV_PRE_ALL, dev);
        go(CMD_MRR, 2'h0, 1'b0, 1'b1); chk("dev", DV_MRR_IDLE, dev);
        go(CMD_ACT, 2'h3, 1'b0, 1'b1); chk("row3", 16'h123, row[3]);
    endtask : t_misc
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #50000;
        failures++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (12) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (24) @(negedge clk_i);
        t_init();
        t_burst();
        t_autopre();
        t_refresh();
        t_misc();
        give_verdict();
    end
endmodule : lpddr_bank_tracker_test
